// >>> rtl/rsc_pkg.sv
// Package of constants for the reset source controller
package rsc_pkg;
   // ==========================================================
   // Register map
   localparam logic [3:0] RSC_MISC_CTRL_ADDR = 4'h0;
   localparam logic [3:0] RSC_STATUS_ADDR = 4'h1;
   localparam logic [3:0] RSC_CAUSE_CFG_ADDR = 4'h2;
   localparam int RSC_PIN_FLAG_BIT = 7;
   localparam int RSC_OSC_SEL_HI_BIT = 5;
   localparam int RSC_OSC_SEL_LO_BIT = 4;
   localparam int RSC_WDT_FLAG_BIT = 1;
   localparam int RSC_PDN_FLAG_BIT = 0;
   localparam logic [1:0] RSC_OSC_SEL_RESET = 2'h0;
   // ==========================================================
   // Timing
   localparam int RSC_CLK_HZ = 40000000;
   localparam int RSC_SLOW_OSC_HZ = 32000;
   localparam int RSC_STARTUP_SMALL_MS = 100;
   localparam int RSC_STARTUP_LARGE_MS = 50;
   localparam int RSC_STARTUP_SMALL_CYC =
      RSC_SLOW_OSC_HZ * RSC_STARTUP_SMALL_MS / 1000;
   localparam int RSC_STARTUP_LARGE_CYC =
      RSC_SLOW_OSC_HZ * RSC_STARTUP_LARGE_MS / 1000;
   localparam int RSC_BROWNOUT_US = 120;
   localparam int RSC_BROWNOUT_CYC =
      (RSC_CLK_HZ / 1000000) * RSC_BROWNOUT_US;
   localparam int RSC_SETTLE_FAST_CYC = 16;
   localparam int RSC_SETTLE_SLOW_CYC = 2;
   localparam int RSC_SLOW_DIV = RSC_CLK_HZ / RSC_SLOW_OSC_HZ;
endpackage

// >>> rtl/rsc_reset_source_controller.sv
// Reset source merging, start-up delay and reset cause flags
// ==============================================================
//
// Chosen here: the strobed register port and the register offsets.
`timescale 1ns/1ps
module rsc_reset_source_controller
   import rsc_pkg::*;
#(
   parameter bit LARGE_PART = 1'b0,
   parameter bit LOW_SUPPLY_EN = 1'b1,
   parameter int LOW_SUPPLY_LEVEL = 0,
   parameter int STARTUP_CYC = LARGE_PART ? RSC_STARTUP_LARGE_CYC :
                                             RSC_STARTUP_SMALL_CYC,
   parameter int BROWNOUT_CYC = RSC_BROWNOUT_CYC,
   parameter int SLOW_DIV = RSC_SLOW_DIV
) (
   input wire logic ref_clk, // System clock, 40 MHz
   input wire logic rst, // Power-on reset, async high
   input wire logic ext_clear_pin_n, // External clear pin, low resets
   input wire logic lowSupply, // Low-supply detector level
   input wire logic wdtExpire, // Watchdog overflow pulse
   input wire logic wdtClr1, // First watchdog clear instruction
   input wire logic wdtClr2, // Second watchdog clear instruction
   input wire logic haltEntry, // Halt instruction pulse
   input wire logic sleepMode, // Core in sleep or idle
   input wire logic wake, // Wake-up event pulse
   input wire logic [3:0] regAddr, // Register address
   input wire logic [7:0] regWdata, // Register write data
   input wire logic regWr, // Write strobe
   input wire logic regRd, // Read strobe
   output logic [7:0] regRdata, // Read data, cycle after strobe
   output logic coreRst, // Full core reset, held in delay
   output logic pcStackClr, // Program counter and stack clear pulse
   output logic runEn, // Core may execute
   output logic intDisable, // Interrupt enables forced off
   output logic wdtClear, // Watchdog counter clear pulse
   output logic timerStop, // Timer/event counter forced off
   output logic portDirSet, // Port directions forced to input
   output logic [1:0] fastOscSel, // Fast oscillator select field
   output logic [1:0] lowSupplyLevel // Static threshold level
);
   // ===========================================================
   // State
   typedef enum logic [3:0] {
      ST_HOLD = 4'h1,
      ST_DELAY = 4'h2,
      ST_RUN = 4'h4,
      ST_SETTLE = 4'h8
   } rsc_state_type;

   typedef struct packed {
      rsc_state_type st;
      logic [1:0] pinSync;
      logic [1:0] lowSync;
      logic [23:0] delayCnt;
      logic [23:0] boCnt;
      logic [15:0] divCnt;
      logic [4:0] settleCnt;
      logic pinFlag;
      logic [1:0] oscSel;
      logic wdtFlag;
      logic pdnFlag;
      logic lastClr2;
      logic pcClr;
      logic wdtClr;
      logic [7:0] rdata;
   } rsc_regs_type;

   rsc_regs_type cur_ff, nxt_ff;
   logic slowTick;
   logic pinLow;
   logic boFire;
   logic pinReset;
   logic [4:0] settleLen;

   always_comb begin
      nxt_ff = cur_ff;
      nxt_ff.pcClr = 1'b0;
      nxt_ff.wdtClr = 1'b0;
      nxt_ff.pinSync = {cur_ff.pinSync[0], ext_clear_pin_n};
      nxt_ff.lowSync = {cur_ff.lowSync[0], lowSupply};
      pinLow = ~cur_ff.pinSync[1];
      // Slow oscillator rate as an enable from the divider
      slowTick = (cur_ff.divCnt == 16'(SLOW_DIV - 1));
      nxt_ff.divCnt = slowTick ? 16'h0 : cur_ff.divCnt + 16'h1;
      // Persistence counter, restarts whenever supply recovers
      boFire = 1'b0;
      if (!LOW_SUPPLY_EN || !cur_ff.lowSync[1]) begin
         nxt_ff.boCnt = 24'h0;
      end else if (cur_ff.boCnt == 24'(BROWNOUT_CYC - 1)) begin
         boFire = 1'b1;
      end else begin
         nxt_ff.boCnt = cur_ff.boCnt + 24'h1;
      end
      pinReset = pinLow || boFire;
      settleLen = (cur_ff.oscSel != 2'h0) ? 5'(RSC_SETTLE_FAST_CYC) :
                                              5'(RSC_SETTLE_SLOW_CYC);
      case (cur_ff.st)
         ST_HOLD: begin
            if (!pinReset) begin
               nxt_ff.st = ST_DELAY;
               nxt_ff.delayCnt = 24'h0;
            end
         end
         ST_DELAY: begin
            if (slowTick) begin
               nxt_ff.delayCnt = cur_ff.delayCnt + 24'h1;
            end
            if (cur_ff.delayCnt == 24'(STARTUP_CYC)) begin
               nxt_ff.st = ST_RUN;
               nxt_ff.wdtClr = 1'b1;
            end
         end
         ST_RUN: begin
            if (wdtExpire && sleepMode) begin
               nxt_ff.pcClr = 1'b1;
               nxt_ff.wdtFlag = 1'b1;
               nxt_ff.pdnFlag = 1'b1;
               nxt_ff.st = ST_SETTLE;
               nxt_ff.settleCnt = 5'h0;
            end else if (wdtExpire) begin
               nxt_ff.wdtFlag = 1'b1;
               nxt_ff.st = ST_DELAY;
               nxt_ff.delayCnt = 24'h0;
            end else if (wake && sleepMode) begin
               nxt_ff.st = ST_SETTLE;
               nxt_ff.settleCnt = 5'h0;
            end
         end
         ST_SETTLE: begin
            nxt_ff.settleCnt = cur_ff.settleCnt + 5'h1;
            // Compare with >= so a select change mid-settle cannot wrap
            if (cur_ff.settleCnt >= settleLen - 5'h1) begin
               nxt_ff.st = ST_RUN;
            end
         end
         default: nxt_ff.st = ST_HOLD;
      endcase
      // Watchdog clears: alternating pair, halt entry, any reset
      if (wdtClr1 && cur_ff.lastClr2) begin
         nxt_ff.wdtClr = 1'b1;
         nxt_ff.lastClr2 = 1'b0;
      end else if (wdtClr2 && !cur_ff.lastClr2) begin
         nxt_ff.wdtClr = 1'b1;
         nxt_ff.lastClr2 = 1'b1;
      end
      if (haltEntry) begin
         nxt_ff.wdtClr = 1'b1;
      end
      // Register writes
      if (regWr && regAddr == RSC_MISC_CTRL_ADDR) begin
         nxt_ff.pinFlag = regWdata[RSC_PIN_FLAG_BIT];
         nxt_ff.oscSel = {regWdata[RSC_OSC_SEL_HI_BIT],
                          regWdata[RSC_OSC_SEL_LO_BIT]};
      end
      // Pin and brownout resets override software writes to the pin flag
      if (pinReset) begin
         nxt_ff.st = ST_HOLD;
         nxt_ff.pinFlag = pinLow;
         nxt_ff.wdtClr = 1'b1;
         nxt_ff.lastClr2 = 1'b0;
      end
      // Register reads, unmapped address reads zero
      nxt_ff.rdata = 8'h0;
      if (regRd) begin
         if (regAddr == RSC_MISC_CTRL_ADDR) begin
            nxt_ff.rdata[RSC_PIN_FLAG_BIT] = cur_ff.pinFlag;
            nxt_ff.rdata[RSC_OSC_SEL_HI_BIT] = cur_ff.oscSel[1];
            nxt_ff.rdata[RSC_OSC_SEL_LO_BIT] = cur_ff.oscSel[0];
         end else if (regAddr == RSC_STATUS_ADDR) begin
            nxt_ff.rdata[RSC_WDT_FLAG_BIT] = cur_ff.wdtFlag;
            nxt_ff.rdata[RSC_PDN_FLAG_BIT] = cur_ff.pdnFlag;
         end else if (regAddr == RSC_CAUSE_CFG_ADDR) begin
            nxt_ff.rdata = {4'h0, cur_ff.st};
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cur_ff <= '0;
         cur_ff.st <= ST_HOLD;
         // Synchroniser starts at the idle pin level, no false pin reset
         cur_ff.pinSync <= 2'h3;
         cur_ff.oscSel <= RSC_OSC_SEL_RESET;
      end else begin
         cur_ff <= nxt_ff;
      end
   end

   // ===========================================================
   // Outputs
   assign regRdata = cur_ff.rdata;
   assign coreRst = cur_ff.st[0] | cur_ff.st[1];
   assign pcStackClr = cur_ff.pcClr | coreRst;
   assign runEn = cur_ff.st[2];
   assign intDisable = coreRst;
   assign wdtClear = cur_ff.wdtClr | coreRst;
   assign timerStop = coreRst;
   assign portDirSet = coreRst;
   assign fastOscSel = cur_ff.oscSel;
   assign lowSupplyLevel = 2'(LOW_SUPPLY_LEVEL);

   // ===========================================================
   // Checks
   sequence s_wdtRun;
      cur_ff.st == ST_RUN && wdtExpire && !sleepMode && !pinReset;
   endsequence

   a_pin_flag_set: assert property (@(posedge ref_clk) disable iff (rst)
      pinLow |=> cur_ff.pinFlag && coreRst)
      else $error("pin reset did not set flag");
   a_wdt_run_reset: assert property (@(posedge ref_clk) disable iff (rst)
      s_wdtRun |=> cur_ff.wdtFlag && coreRst &&
      cur_ff.pinFlag == $past(cur_ff.pinFlag))
      else $error("watchdog run reset wrong");
   a_wdt_sleep_clr: assert property (@(posedge ref_clk) disable iff (rst)
      (cur_ff.st == ST_RUN && wdtExpire && sleepMode && !pinReset)
      |=> pcStackClr && !coreRst && cur_ff.pdnFlag)
      else $error("sleep watchdog wrong");
   a_brownout_short: assert property (@(posedge ref_clk) disable iff (rst)
      !cur_ff.lowSync[1] |=> cur_ff.boCnt == 24'h0)
      else $error("brownout count not restarted");
   a_unused_zero: assert property (@(posedge ref_clk) disable iff (rst)
      $past(regRd && regAddr == RSC_MISC_CTRL_ADDR)
      |-> (regRdata & 8'h4f) == 8'h0)
      else $error("unimplemented bits nonzero");
   a_delay_hold: assert property (@(posedge ref_clk) disable iff (rst)
      (cur_ff.st == ST_DELAY && cur_ff.delayCnt != 24'(STARTUP_CYC))
      |-> !runEn && intDisable && portDirSet)
      else $error("ran before start-up delay");
   a_settle_len: assert property (@(posedge ref_clk) disable iff (rst)
      ($rose(cur_ff.st == ST_SETTLE) && cur_ff.oscSel == 2'h0 && !pinReset)
      |-> !runEn ##1 !runEn ##1 (runEn || coreRst))
      else $error("slow settle length wrong");
   a_wdt_alt_clr: assert property (@(posedge ref_clk) disable iff (rst)
      (wdtClr1 && !cur_ff.lastClr2 && !haltEntry && !pinReset &&
      cur_ff.st == ST_RUN && !wdtExpire && !wdtClr2) |=> !wdtClear)
      else $error("repeated clear accepted");

   // ===========================================================
   // Further checks
   sequence s_ctrlWrite;
      regWr && regAddr == RSC_MISC_CTRL_ADDR && !pinReset;
   endsequence

   sequence s_fastSettle;
      $rose(cur_ff.st == ST_SETTLE) && cur_ff.oscSel != 2'h0 && !pinReset;
   endsequence

   sequence s_runQuiet;
      runEn && !wdtExpire && !pinLow;
   endsequence

   a_pin_pc_zero: assert property (
      @(posedge ref_clk) disable iff (rst)
      pinLow |=> pcStackClr && !runEn)
      else $error("pin reset did not clear program counter");

   a_flag_write: assert property (
      @(posedge ref_clk) disable iff (rst)
      s_ctrlWrite |=>
      cur_ff.pinFlag == 1'($past(regWdata) >> RSC_PIN_FLAG_BIT))
      else $error("software write to pin flag lost");

   a_osc_write: assert property (
      @(posedge ref_clk) disable iff (rst)
      s_ctrlWrite |=>
      fastOscSel == 2'($past(regWdata) >> RSC_OSC_SEL_LO_BIT))
      else $error("oscillator select write lost");

   a_bo_fire: assert property (
      @(posedge ref_clk) disable iff (rst)
      boFire |=> coreRst && !runEn)
      else $error("brownout terminal count gave no reset");

   a_bo_ignore: assert property (
      @(posedge ref_clk) disable iff (rst)
      (s_runQuiet ##0 cur_ff.boCnt != 24'(BROWNOUT_CYC - 1))
      |=> !coreRst)
      else $error("short supply dip caused a reset");

   a_bo_flag: assert property (
      @(posedge ref_clk) disable iff (rst)
      (boFire && !pinLow) |=> !cur_ff.pinFlag && coreRst)
      else $error("brownout reset left pin flag set");

   a_cause_keep: assert property (
      @(posedge ref_clk) disable iff (rst)
      (pinReset && !wdtExpire) |=>
      $stable(cur_ff.wdtFlag) && $stable(cur_ff.pdnFlag))
      else $error("pin or brownout reset changed cause flags");

   a_flag_sticky: assert property (
      @(posedge ref_clk) disable iff (rst)
      cur_ff.wdtFlag |=> cur_ff.wdtFlag)
      else $error("watchdog flag cleared by hardware");

   a_delay_end: assert property (
      @(posedge ref_clk) disable iff (rst)
      (cur_ff.st == ST_DELAY && cur_ff.delayCnt == 24'(STARTUP_CYC) &&
      !pinReset) |=> runEn && wdtClear)
      else $error("watchdog not restarted at delay end");

   a_halt_clr: assert property (
      @(posedge ref_clk) disable iff (rst)
      haltEntry |=> wdtClear)
      else $error("halt entry did not clear watchdog");

   a_settle_fast: assert property (
      @(posedge ref_clk) disable iff (rst)
      s_fastSettle |-> ##15 !runEn ##1 (runEn || coreRst))
      else $error("fast settle length wrong");

   a_reset_outs: assert property (
      @(posedge ref_clk) disable iff (rst)
      coreRst |-> intDisable && timerStop && portDirSet && !runEn)
      else $error("reset left interrupts, timer or ports active");

   a_read_once: assert property (
      @(posedge ref_clk) disable iff (rst)
      !$past(regRd) |-> regRdata == 8'h00)
      else $error("read data outside its cycle");

   a_state_onehot: assert property (
      @(posedge ref_clk) disable iff (rst)
      $onehot(cur_ff.st))
      else $error("state not one-hot");
endmodule

// >>> sim/rsc_clear_pin_model.sv
// External reset circuit model that drives the clear pin
`timescale 1ns/1ps
module rsc_clear_pin_model (
   input wire logic ref_clk, // System clock
   input wire logic holdReq, // Start a low pulse on the pin
   input wire logic [7:0] holdCycles, // Length of the low pulse
   output logic ext_clear_pin_n // Clear pin, pulled up when idle
);
   logic [7:0] cnt_ff = 8'h00;
   always @(posedge ref_clk) begin
      if (holdReq) begin
         cnt_ff <= holdCycles;
      end else if (cnt_ff != 8'h00) begin
         cnt_ff <= cnt_ff - 8'h01;
      end
   end
   // Pull-up returns the pin high once the pulse ends
   assign ext_clear_pin_n = (cnt_ff == 8'h00);
endmodule

// >>> sim/tb_rsc_reset_source_controller.sv
// Self-checking bench for the reset source controller
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
$display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module tb_rsc_reset_source_controller;
   import rsc_pkg::*;
   localparam int BO = 8;
   logic ref_clk = 1'b0, rst = 1'b1, lowSupply = 1'b0, wdtExpire = 1'b0;
   logic wdtClr1 = 1'b0, wdtClr2 = 1'b0, haltEntry = 1'b0, sleepMode = 1'b0;
   logic regWr = 1'b0, regRd = 1'b0, holdReq = 1'b0, extClearN;
   logic [3:0] regAddr = 4'h0;
   logic [7:0] regWdata = 8'h00, regRdata;
   logic [1:0] fastOscSel, lowSupplyLevel;
   logic coreRst, pcStackClr, runEn, intDisable, wdtClear, timerStop;
   logic portDirSet;
   int n_mismatch = 0, checked = 0, n, m;
   logic [2:0] clrSeq [6] = '{3'h4, 3'h4, 3'h2, 3'h2, 3'h4, 3'h1};
   logic clrExp [6] = '{1'bx, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
   rsc_reset_source_controller #(.LOW_SUPPLY_LEVEL(2), .STARTUP_CYC(4),
      .BROWNOUT_CYC(BO), .SLOW_DIV(2)) i_rsc_reset_source_controller (
      .ref_clk(ref_clk), .rst(rst), .ext_clear_pin_n(extClearN),
      .lowSupply(lowSupply), .wdtExpire(wdtExpire), .wdtClr1(wdtClr1),
      .wdtClr2(wdtClr2), .haltEntry(haltEntry), .sleepMode(sleepMode),
      .wake(1'b0), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
      .regRd(regRd), .regRdata(regRdata), .coreRst(coreRst),
      .pcStackClr(pcStackClr), .runEn(runEn), .intDisable(intDisable),
      .wdtClear(wdtClear), .timerStop(timerStop), .portDirSet(portDirSet),
      .fastOscSel(fastOscSel), .lowSupplyLevel(lowSupplyLevel));
   rsc_clear_pin_model i_rsc_clear_pin_model (.ref_clk(ref_clk),
      .holdReq(holdReq), .holdCycles(8'h06), .ext_clear_pin_n(extClearN));
   always #12.5 ref_clk = ~ref_clk;
   // ==========================================================
   // Bus and sequencing tasks
   task wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge ref_clk);
      regWr <= 1'b0;
   endtask
   task rchk(input logic [3:0] a, input logic [7:0] e);
      @(posedge ref_clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge ref_clk);
      regRd <= 1'b0;
      #1;
      `CHK("regRdata", e, regRdata)
   endtask
   task pulse(input logic [1:0] w);
      @(posedge ref_clk);
      {holdReq, wdtExpire} <= w;
      @(posedge ref_clk);
      {holdReq, wdtExpire} <= 2'h0;
   endtask
   // Bounded wait for runEn (run=1) or coreRst (run=0)
   task waitFor(input bit run);
      n = 0;
      while ((run ? runEn : coreRst) !== 1'b1 && n < 300) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      `CHK("waitDone", 1'b1, n < 300)
   endtask
   task resetChk;
      `CHK("resetOuts", 7'h7e, {coreRst, intDisable, timerStop, portDirSet,
         pcStackClr, wdtClear, runEn})
   endtask
   task clrChk(input logic [2:0] v, input logic e);
      @(posedge ref_clk);
      {wdtClr1, wdtClr2, haltEntry} <= v;
      @(posedge ref_clk);
      {wdtClr1, wdtClr2, haltEntry} <= 3'h0;
      n = 0;
      repeat (3) begin
         #1;
         if (wdtClear === 1'b1) n++;
         @(posedge ref_clk);
      end
      if (e !== 1'bx) `CHK("wdtClear", e, n != 0)
   endtask
   task end_of_test;
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // ==========================================================
   // Tests
   initial begin
      repeat (3) @(posedge ref_clk);
      rst <= 1'b0;
      waitFor(1'b1);
      `CHK("lowSupplyLevel", 2'h2, lowSupplyLevel)
      rchk(RSC_MISC_CTRL_ADDR, 8'h00);
      rchk(RSC_STATUS_ADDR, 8'h00);
      wr(RSC_MISC_CTRL_ADDR, 8'hff);
      rchk(RSC_MISC_CTRL_ADDR, 8'hb0);
      `CHK("fastOscSel", 2'h3, fastOscSel)
      wr(RSC_STATUS_ADDR, 8'hff);
      rchk(RSC_STATUS_ADDR, 8'h00);
      rchk(4'hf, 8'h00);
      wr(RSC_MISC_CTRL_ADDR, 8'h00);
      $display("test registers done");
      for (int i = 0; i < 6; i++) clrChk(clrSeq[i], clrExp[i]);
      $display("test watchdog clears done");
      pulse(2'h2);
      waitFor(1'b0);
      resetChk();
      waitFor(1'b1);
      rchk(RSC_MISC_CTRL_ADDR, 8'h80);
      rchk(RSC_STATUS_ADDR, 8'h00);
      $display("test pin reset done");
      pulse(2'h1);
      waitFor(1'b0);
      resetChk();
      waitFor(1'b1);
      rchk(RSC_MISC_CTRL_ADDR, 8'h80);
      rchk(RSC_STATUS_ADDR, 8'h02);
      $display("test watchdog run done");
      @(posedge ref_clk);
      lowSupply <= 1'b1;
      repeat (BO - 3) @(posedge ref_clk);
      lowSupply <= 1'b0;
      m = 0;
      repeat (20) @(posedge ref_clk) if (coreRst !== 1'b0) m++;
      `CHK("shortDip", 0, m)
      lowSupply <= 1'b1;
      waitFor(1'b0);
      lowSupply <= 1'b0;
      resetChk();
      waitFor(1'b1);
      rchk(RSC_MISC_CTRL_ADDR, 8'h00);
      rchk(RSC_STATUS_ADDR, 8'h02);
      $display("test brownout done");
      for (int k = 1; k >= 0; k--) begin
         wr(RSC_MISC_CTRL_ADDR, k ? 8'h10 : 8'h00);
         sleepMode <= 1'b1;
         pulse(2'h1);
         n = 0;
         m = 0;
         repeat (40) begin
            #1;
            if (runEn !== 1'b1) n++;
            if (pcStackClr === 1'b1) m++;
            if (coreRst !== 1'b0) m += 10;
            @(posedge ref_clk);
         end
         `CHK("settleLen", 1'b1, n >= (k ? 15 : 1) && n <= (k ? 17 : 3))
         `CHK("pcStackPulse", 1, m)
         sleepMode <= 1'b0;
         rchk(RSC_STATUS_ADDR, 8'h03);
         rchk(RSC_MISC_CTRL_ADDR, k ? 8'h10 : 8'h00);
      end
      $display("test watchdog sleep done");
      end_of_test();
   end
   initial begin
      #100000;
      n_mismatch++;
      end_of_test();
   end
endmodule
